// *** include/apr_pkg.sv ***
// Purpose: shared constants and types for the adc power and reset control
// Assumes: 50 MHz system clock, four conversion channels, 12-bit codes
// Notes:   times are kept in their own unit; cycle counts derive from them
package apr_pkg;
  localparam int          CLK_MHZ        = 50;
  localparam int          NUM_CH         = 4;
  localparam int          CODE_W         = 12;
  // clock monitor limits
  localparam int          STOP_NS        = 300;
  localparam int          MIN_FREQ_KHZ   = 3000;
  // stop: longest time rounds down
  localparam int          STOP_CYC       = (STOP_NS * CLK_MHZ) / 1000;
  // slowest allowed period in system cycles (rounded down)
  localparam int          SLOW_CYC       = (CLK_MHZ * 1000) / MIN_FREQ_KHZ;
  localparam int          MON_W          = 8;
  localparam logic [MON_W-1:0] STOP_LIM  = MON_W'(STOP_CYC);
  localparam logic [MON_W-1:0] SLOW_LIM  = MON_W'(SLOW_CYC);
  // serial clock generation: bit clock 12x, frame clock 1x, derived here
  localparam int          BIT_DIV        = 2;
  localparam int          FRAME_BITS     = 6;
  localparam logic [2:0]  FRAME_HALF     = 3'(FRAME_BITS - 1);
  // reset values of configuration
  localparam logic [NUM_CH-1:0] CH_PD_RST = 4'h0;
  localparam logic [CODE_W-1:0] ZERO_CODE = 12'h000;
  localparam logic [NUM_CH*CODE_W-1:0] ZERO_CODE_ALL = 48'h000000000000;

  typedef enum logic [1:0] {
    APR_RUN     = 2'b00,
    APR_PARTIAL = 2'b01,
    APR_GLOBAL  = 2'b11
  } apr_state_type;
endpackage : apr_pkg

// *** include/apr_mon_if.sv ***
// Purpose: carries clock monitor results between monitor and controller
// Assumes: single system clock domain
// Notes:   monitor drives, controller reads
`timescale 1ns/100ps
interface apr_mon_if;
  logic clk_bad;   // stop or too slow detected
  logic edge_seen; // synchronised rising edge of the sample clock
  modport mon (output clk_bad, output edge_seen);
  modport ctl (input clk_bad, input edge_seen);
endinterface : apr_mon_if

// *** rtl/apr_clk_monitor.sv ***
// Purpose: watches the sampling clock for stop or low frequency
// Assumes: sample clock sampled by the 50 MHz system clock
// Notes:   limit is the wider of stop time and slowest period
`timescale 1ns/100ps
module apr_clk_monitor
  import apr_pkg::*;
(
  input  wire logic clk,        // system clock
  input  wire logic rst_n,      // synchronous reset, active low
  input  wire logic sample_clk, // sampling clock level
  apr_mon_if.mon    mon         // monitor results
);
  logic [2:0]       sync_reg;
  logic [MON_W-1:0] cnt_reg;
  logic [MON_W-1:0] cnt_next;
  logic             bad_reg;
  logic             rise;
  logic [MON_W-1:0] lim;

  // stop and slow both show as too long between edges
  assign lim      = (STOP_LIM > SLOW_LIM) ? STOP_LIM : SLOW_LIM;
  assign rise     = sync_reg[1] & ~sync_reg[2];
  assign cnt_next = rise ? '0 :
                    (cnt_reg == lim) ? cnt_reg : cnt_reg + 1'b1;

  // first stage read only by the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_reg <= 3'h0;
      cnt_reg  <= '0;
      bad_reg  <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[1:0], sample_clk};
      cnt_reg  <= cnt_next;
      bad_reg  <= (cnt_next == lim);
    end
  end

  assign mon.clk_bad   = bad_reg;
  assign mon.edge_seen = rise;
endmodule : apr_clk_monitor

// *** rtl/apr_power_reset_ctrl.sv ***
// Purpose: power-down, clock-stop supervision and reset control
// Assumes: controller drives power_down_pin, rst_n and the sampling clock
// Notes:   analog enables are plain level outputs toward the analog blocks
//
// Summary of operation
// - power_down_pin high puts the device in global power-down.
// - global power-down turns off reference, clock circuitry, channels.
// - global power-down tri-states all serial output drivers.
// - each channel powers down alone via its configuration bits.
// - clock stopped over 300 ns or below 3 MHz gives partial power-down.
// - reset returns every configuration register to 0.
// - during reset every channel sends an all-zero code.
// - bit and frame clocks keep toggling through reset.
`timescale 1ns/100ps
module apr_power_reset_ctrl
  import apr_pkg::*;
(
  input  wire logic                    clk,            // system clock
  input  wire logic                    rst_n,          // sync reset, low
  input  wire logic                    power_down_pin, // pin, high = off
  input  wire logic                    sample_clock_in,// sampling clock
  input  wire logic                    cfg_wr,         // config write
  input  wire logic [apr_pkg::NUM_CH-1:0] cfg_ch_pd,   // per-channel off
  input  wire logic [apr_pkg::NUM_CH*apr_pkg::CODE_W-1:0] adc_code,
                                                       // channel codes
  output logic                         ref_en,         // reference on
  output logic                         clk_circ_en,    // clock circuits on
  output logic [apr_pkg::NUM_CH-1:0]   ch_en,          // channel enables
  output logic [apr_pkg::NUM_CH-1:0]   lvds_oe,        // data driver on
  output logic                         clk_out_oe,     // clock drivers on
  output logic [apr_pkg::NUM_CH*apr_pkg::CODE_W-1:0] out_code,
                                                       // codes to serializer
  output logic                         serial_bit_clock_out, // 12x clock
  output logic                         frame_clock_out,// 1x clock
  output logic                         partial_pd,     // partial power-down
  output logic                         global_pd       // global power-down
);
  // monitor results travel in their own bundle
  apr_mon_if mon_if ();

  // pin synchroniser
  logic [1:0]               pd_sync_reg;
  logic                     pd_level;

  // channel configuration
  logic [NUM_CH-1:0]        ch_pd_reg;
  logic [NUM_CH-1:0]        ch_pd_next;

  // mode state and its decodes
  apr_state_type            state_reg;
  apr_state_type            state_next;
  logic                     running;
  logic                     next_run;
  logic                     next_global;
  logic                     next_partial;

  // registered enables toward the analog side and the drivers
  logic                     ref_en_reg;
  logic                     ref_en_next;
  logic                     clk_en_reg;
  logic                     clk_en_next;
  logic [NUM_CH-1:0]        ch_en_reg;
  logic [NUM_CH-1:0]        ch_en_next;
  logic [NUM_CH-1:0]        oe_reg;
  logic [NUM_CH-1:0]        oe_next;
  logic                     clk_oe_reg;
  logic                     clk_oe_next;

  // registered mode flags, so the flag outputs come from flops
  logic                     part_reg;
  logic                     glob_reg;

  // data path toward the serializer
  logic [NUM_CH*CODE_W-1:0] code_reg;
  logic [NUM_CH*CODE_W-1:0] code_next;

  // free-running output clocks; start values stand in for a reset,
  // since rst_n must not touch them
  logic                     bit_reg   = 1'b0;
  logic                     bit_next;
  logic [2:0]               fcnt_reg  = 3'h0;
  logic [2:0]               fcnt_next;
  logic                     frame_reg = 1'b0;
  logic                     frame_next;
  logic                     frame_wrap;

  // true when no power-down mode holds; channels still follow their configuration bits
  function automatic logic mode_is_run(input apr_state_type s);
    return (s == APR_RUN);
  endfunction : mode_is_run

  // true when the pin has taken the whole device down
  function automatic logic mode_is_global(input apr_state_type s);
    return (s == APR_GLOBAL);
  endfunction : mode_is_global

  // true when only the clock monitor has shut things down
  function automatic logic mode_is_partial(input apr_state_type s);
    return (s == APR_PARTIAL);
  endfunction : mode_is_partial

  // clock monitor on the synchronised sampling clock
  apr_clk_monitor u_mon (
    .clk        (clk),
    .rst_n      (rst_n),
    .sample_clk (sample_clock_in),
    .mon        (mon_if.mon)
  );

  // pin passes two flops before use; a pure delay, so no reset
  always_ff @(posedge clk) begin
    pd_sync_reg <= {pd_sync_reg[0], power_down_pin};
  end
  assign pd_level = pd_sync_reg[1];

  // mode selection; global outranks partial, so a clock stop seen
  // during power-down is ignored until the pin lets go
  always_comb begin
    case (state_reg)
      APR_RUN: begin
        if (pd_level) begin
          state_next = APR_GLOBAL;
        end else if (mon_if.clk_bad) begin
          state_next = APR_PARTIAL;
        end else begin
          state_next = APR_RUN;
        end
      end
      APR_PARTIAL: begin
        if (pd_level) begin
          state_next = APR_GLOBAL;
        end else if (mon_if.clk_bad) begin
          state_next = APR_PARTIAL;
        end else begin
          state_next = APR_RUN;
        end
      end
      APR_GLOBAL: begin
        state_next = pd_level ? APR_GLOBAL : APR_RUN;
      end
      default: begin
        state_next = APR_GLOBAL;
      end
    endcase
  end

  // configuration keeps its value until written; reset clears it
  assign ch_pd_next   = cfg_wr ? cfg_ch_pd : ch_pd_reg;

  // mode decodes, shared by enables, flags and the data path
  assign running      = mode_is_run(state_reg);
  assign next_run     = mode_is_run(state_next);
  assign next_global  = mode_is_global(state_next);
  assign next_partial = mode_is_partial(state_next);

  // enables decode the coming mode, so enables and mode flags change
  // on the same edge and never disagree for a cycle
  assign ref_en_next  = !next_global;
  assign clk_en_next  = next_run;
  assign ch_en_next   = next_run ? ~ch_pd_next : '0;
  assign oe_next      = next_global ? '0 : '1;
  assign clk_oe_next  = !next_global;

  // zero code unless running with the channel on; reset adds its own
  // clear below, so zeros also stand during reset
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      assign code_next[g*CODE_W +: CODE_W] =
        (running && !ch_pd_reg[g]) ? adc_code[g*CODE_W +: CODE_W]
                                   : ZERO_CODE;
    end
  endgenerate

  // state and configuration
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= APR_RUN;
      ch_pd_reg <= CH_PD_RST;
    end else begin
      state_reg <= state_next;
      ch_pd_reg <= ch_pd_next;
    end
  end

  // analog enables; on during reset, as the configuration is cleared
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_en_reg <= 1'b1;
      clk_en_reg <= 1'b1;
      ch_en_reg  <= '1;
    end else begin
      ref_en_reg <= ref_en_next;
      clk_en_reg <= clk_en_next;
      ch_en_reg  <= ch_en_next;
    end
  end

  // driver enables; only global power-down floats the outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oe_reg     <= '1;
      clk_oe_reg <= 1'b1;
    end else begin
      oe_reg     <= oe_next;
      clk_oe_reg <= clk_oe_next;
    end
  end

  // mode flags track state_reg exactly, one flop each
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      part_reg <= 1'b0;
      glob_reg <= 1'b0;
    end else begin
      part_reg <= next_partial;
      glob_reg <= next_global;
    end
  end

  // output codes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code_reg <= ZERO_CODE_ALL;
    end else begin
      code_reg <= code_next;
    end
  end

  // bit clock toggles every edge; frame counter steps on its high half
  assign bit_next   = ~bit_reg;
  assign frame_wrap = bit_reg && (fcnt_reg == FRAME_HALF);
  assign fcnt_next  = !bit_reg ? fcnt_reg :
                      (frame_wrap ? 3'h0 : fcnt_reg + 3'h1);
  assign frame_next = frame_wrap ? ~frame_reg : frame_reg;

  // output clocks ignore rst_n so they keep running through reset
  always_ff @(posedge clk) begin
    bit_reg   <= bit_next;
    fcnt_reg  <= fcnt_next;
    frame_reg <= frame_next;
  end

  // every output straight from its flop
  assign ref_en               = ref_en_reg;
  assign clk_circ_en          = clk_en_reg;
  assign ch_en                = ch_en_reg;
  assign lvds_oe              = oe_reg;
  assign clk_out_oe           = clk_oe_reg;
  assign out_code             = code_reg;
  assign serial_bit_clock_out = bit_reg;
  assign frame_clock_out      = frame_reg;
  assign partial_pd           = part_reg;
  assign global_pd            = glob_reg;
endmodule : apr_power_reset_ctrl

// *** sim/apr_ctl_model.sv ***
// Purpose: controller side model that makes the sampling clock
// Assumes: steps on the system clock, just after its rising edge
// Notes:   a stopped clock holds low, as a gated source would
`timescale 1ns/100ps
module apr_ctl_model (
  input  wire logic       clk,       // system clock
  input  wire logic       run,       // sampling clock running
  input  wire logic [4:0] half,      // half period in clk cycles
  output logic            sample_clk // sampling clock to the device
);
  logic [4:0] cnt_reg = 5'h00; // cycles into this half period
  initial sample_clk = 1'b0;
  // slow half periods push the rate under the monitor limit
  always @(posedge clk) begin
    if (!run) begin
      cnt_reg <= 5'h00;
      sample_clk <= 1'b0;
    end else if (cnt_reg + 5'h01 >= half) begin
      cnt_reg <= 5'h00;
      sample_clk <= ~sample_clk;
    end else cnt_reg <= cnt_reg + 5'h01;
  end
endmodule : apr_ctl_model

// *** sim/apr_checker.sv ***
// Purpose: port checks for power-down, clock stop and reset
// Assumes: one clock, synchronous active-low reset
// Notes:   gap counts cycles since the sample clock last rose
`timescale 1ns/100ps
module apr_checker
  import apr_pkg::*;
(
  input wire logic clk, rst_n, power_down_pin, sample_clock_in, cfg_wr,
  input wire logic [apr_pkg::NUM_CH-1:0] cfg_ch_pd, ch_en, lvds_oe,
  input wire logic ref_en, clk_circ_en, clk_out_oe, partial_pd, global_pd,
  input wire logic serial_bit_clock_out, frame_clock_out,
  input wire logic [apr_pkg::NUM_CH*apr_pkg::CODE_W-1:0] out_code
);
  logic [7:0] gap_reg;        // cycles since last rise
  logic [1:0] up_reg = 2'h0;  // edges since start, guards $past
  logic       smp_reg;        // sample clock one cycle ago
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // the gap runs ahead of the device's synchroniser by a few cycles
  always_ff @(posedge clk) begin
    smp_reg <= sample_clock_in;
    if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
    if (!rst_n || (sample_clock_in && !smp_reg)) gap_reg <= 8'h00;
    else if (gap_reg != 8'hFF) gap_reg <= gap_reg + 8'h01;
  end
  chk_pin_global: assert property (power_down_pin [*5] |-> global_pd)
    else $error("pin high without global power-down");
  chk_global_off: assert property (global_pd |-> !ref_en
    && !clk_circ_en && ch_en == '0) else $error("blocks on in power-down");
  chk_global_hiz: assert property (global_pd |-> lvds_oe == '0
    && !clk_out_oe) else $error("drivers on in power-down");
  chk_stop_partial: assert property (gap_reg == 8'h16 |-> partial_pd
    || global_pd) else $error("stopped clock not detected");
  chk_partial_exit: assert property (partial_pd && $rose(sample_clock_in)
    |-> ##[1:6] !partial_pd) else $error("partial power-down stuck");
  chk_cfg_apply: assert property (cfg_wr ##1 !(partial_pd || global_pd)
    |-> ch_en == ~$past(cfg_ch_pd)) else $error("channel config wrong");
  chk_rst_default: assert property (disable iff (1'b0) !rst_n |=>
    ch_en == '1 && !partial_pd) else $error("config not cleared");
  chk_rst_code: assert property (disable iff (1'b0) !rst_n |=>
    out_code == '0) else $error("nonzero code in reset");
  chk_bit_clock: assert property (disable iff (1'b0) up_reg == 2'h3 |->
    serial_bit_clock_out != $past(serial_bit_clock_out))
    else $error("bit clock stalled");
  chk_frame_period: assert property (disable iff (1'b0) up_reg == 2'h3
    && $changed(frame_clock_out) |=> $stable(frame_clock_out) [*8] ##1
    $stable(frame_clock_out) [*3] ##1 $changed(frame_clock_out))
    else $error("frame clock period wrong");
  cover property (global_pd);
  cover property (partial_pd ##1 !partial_pd);
  cover property (cfg_wr ##1 ch_en != 4'hF);
endmodule : apr_checker

// *** sim/adc_power_reset_control_test.sv ***
// Purpose: directed bench for power-down, clock stop and reset
// Assumes: 50 MHz clock, reset held six cycles at start
// Notes:   flag waits are bounded, so a hang ends in a fail
`timescale 1ns/100ps
module adc_power_reset_control_test;
  logic        clk = 1'b0, rst_n = 1'b0, power_down_pin = 1'b0;
  logic        cfg_wr = 1'b0, run = 1'b1;
  logic [3:0]  cfg_ch_pd = 4'h0;
  logic [4:0]  half = 5'h03;
  logic [47:0] adc_code = 48'h8A35C1F0E2B7;
  logic        sample_clock_in, ref_en, clk_circ_en, clk_out_oe;
  logic        serial_bit_clock_out, frame_clock_out, partial_pd, global_pd;
  logic [3:0]  ch_en, lvds_oe;
  logic [47:0] out_code;
  int          failures = 0, cmp_count = 0, n;
  // 20 ns period
  always #10 clk = ~clk;
  apr_ctl_model ctl (.clk, .run, .half, .sample_clk(sample_clock_in));
  apr_power_reset_ctrl dut (.clk, .rst_n, .power_down_pin, .sample_clock_in,
    .cfg_wr, .cfg_ch_pd, .adc_code, .ref_en, .clk_circ_en, .ch_en, .lvds_oe,
    .clk_out_oe, .out_code, .serial_bit_clock_out, .frame_clock_out,
    .partial_pd, .global_pd);
  task automatic chk(input string what, input logic [47:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // samples 1 ns after each edge so registered outputs have landed
  task automatic wait_on(ref logic s, input logic v, output int k);
    k = 0;
    while (s !== v && k < 90) begin
      @(posedge clk);
      #1 k++;
    end
  endtask : wait_on
  task automatic t_reset;
    logic b;
    repeat (2) @(posedge clk);
    #1 b = serial_bit_clock_out;
    @(posedge clk);
    #1 chk("bit clock in reset", !b, serial_bit_clock_out);
    chk("code in reset", 48'h0, out_code);
    chk("enables in reset", 4'hF, ch_en);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    #1 chk("run code", adc_code, out_code);
    $display("test reset done");
  endtask : t_reset
  task automatic t_cfg;
    @(posedge clk) begin
      cfg_wr <= 1'b1;
      cfg_ch_pd <= 4'h5;
    end
    @(posedge clk) cfg_ch_pd <= 4'hA;
    #1 chk("first write", 4'hA, ch_en);
    @(posedge clk) cfg_wr <= 1'b0;
    #1 chk("second write", 4'h5, ch_en);
    @(posedge clk);
    #1 chk("channel codes", adc_code & 48'h000FFF000FFF, out_code);
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    #1 chk("config cleared", 4'hF, ch_en);
    $display("test config done");
  endtask : t_cfg
  task automatic t_global;
    @(posedge clk) power_down_pin <= 1'b1;
    wait_on(global_pd, 1'b1, n);
    chk("global entry", 1'b1, global_pd && n <= 4);
    chk("analog enables", 6'h00, {ref_en, clk_circ_en, ch_en});
    chk("driver enables", 5'h00, {lvds_oe, clk_out_oe});
    @(posedge clk) power_down_pin <= 1'b0;
    wait_on(global_pd, 1'b0, n);
    chk("drivers back", 5'h1F, {lvds_oe, clk_out_oe});
    $display("test global done");
  endtask : t_global
  task automatic t_stop;
    @(posedge clk) run <= 1'b0;
    wait_on(partial_pd, 1'b1, n);
    chk("stop detect", 1'b1, partial_pd && n > 11 && n < 30);
    chk("channels idle", 4'h0, ch_en);
    @(posedge clk) run <= 1'b1;
    wait_on(partial_pd, 1'b0, n);
    chk("auto exit", 1'b1, !partial_pd && n < 12);
    @(posedge clk) run <= 1'b0;
    repeat (5) @(posedge clk);
    run <= 1'b1;
    wait_on(partial_pd, 1'b1, n);
    chk("short stop", 1'b0, partial_pd);
    @(posedge clk) half <= 5'h0C;
    wait_on(partial_pd, 1'b1, n);
    chk("slow clock", 1'b1, partial_pd);
    @(posedge clk) half <= 5'h03;
    $display("test clock stop done");
  endtask : t_stop
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // all tests take well under 5000 cycles
  initial begin
    #100000 failures++;
    give_verdict;
  end
  initial begin
    t_reset;
    t_cfg;
    t_global;
    t_stop;
    give_verdict;
  end
endmodule : adc_power_reset_control_test
bind apr_power_reset_ctrl apr_checker chk_i (.clk, .rst_n, .power_down_pin,
  .sample_clock_in, .cfg_wr, .cfg_ch_pd, .ch_en, .lvds_oe, .ref_en,
  .clk_circ_en, .clk_out_oe, .partial_pd, .global_pd, .out_code,
  .serial_bit_clock_out, .frame_clock_out);
